// file: evr_chan_if.sv
// Bundle between the router top and one channel engine.
// Assumes both ends run on ref_clk; all signals are same-domain levels or pulses.
`timescale 1ns/100ps
interface evr_chan_if;
    import evr_pkg::*;
    logic tick;        // Channel clock enable pulse
    logic clr;         // Soft reset pulse
    logic [1:0] path;  // Path select
    logic [1:0] edge_sel; // Edge select
    logic src;         // Selected generator level
    logic sw;          // Software event pulse
    logic all_ready;   // All users on this channel ready
    logic evt;         // Event pulse towards users
    logic busy;        // Channel busy status
    logic ovr;         // Overrun pulse
    logic evd;         // Generator event detected pulse
    logic clk_req;     // Channel clock request

    modport chan (input tick, clr, path, edge_sel, src, sw, all_ready,
                  output evt, busy, ovr, evd, clk_req);
    modport ctl (output tick, clr, path, edge_sel, src, sw, all_ready,
                 input evt, busy, ovr, evd, clk_req);
endinterface : evr_chan_if

// file: evr_channel.sv
// One event channel engine: resync, edge detect, software event, busy and overrun.
// Assumes tick is a one-cycle enable standing in for the channel clock.
`timescale 1ns/100ps
module evr_channel
    import evr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    evr_chan_if.chan ch
);

    logic rs1_q;      // Resync first stage, read only by rs2_q
    logic rs2_q;      // Resync second stage
    logic prev_q;     // Level seen at the previous tick
    logic sw_pend_q;  // Software event waiting for a tick
    logic evt_q;      // Event pulse to users
    logic busy_q;     // Event not yet taken by all users
    logic ovr_q;      // Overrun pulse
    logic evd_q;      // Generator event pulse
    logic req_q;      // Clock request

    // Clocked paths must not run on the asynchronous path
    wire clocked = (ch.path != PATH_ASYNC);
    // Resync path adds two flops because the generator clock is foreign
    wire lvl = (ch.path == PATH_RESYNC) ? rs2_q : ch.src;
    wire rise = lvl & ~prev_q;
    wire fall = ~lvl & prev_q;
    wire edge_hit = ((ch.edge_sel == EDGE_RISE) & rise) | ((ch.edge_sel == EDGE_FALL) & fall) |
                    ((ch.edge_sel == EDGE_BOTH) & (rise | fall));
    wire gen_go = ch.tick & clocked & edge_hit;
    wire sw_go = ch.tick & clocked & sw_pend_q;
    wire new_evt = gen_go | sw_go;

    // Two-flop resynchroniser
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end else begin
            rs1_q <= ch.src;
            rs2_q <= rs1_q;
        end
    end

    // Edge sampling and event pulse, one tick of latency at most
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_q <= 1'b0;
            evt_q <= 1'b0;
            evd_q <= 1'b0;
        end else if (ch.clr) begin
            prev_q <= 1'b0;
            evt_q <= 1'b0;
            evd_q <= 1'b0;
        end else begin
            if (ch.tick) begin
                prev_q <= lvl;
            end
            evt_q <= new_evt;
            evd_q <= gen_go;
        end
    end

    // Software event is held until the next channel tick
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sw_pend_q <= 1'b0;
        end else if (ch.clr) begin
            sw_pend_q <= 1'b0;
        end else begin
            sw_pend_q <= ch.sw | (sw_pend_q & ~sw_go);
        end
    end

    // Busy stays up until every attached user is ready; overrun on a clash
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= 1'b0;
            ovr_q <= 1'b0;
        end else if (ch.clr || !clocked) begin
            busy_q <= 1'b0;
            ovr_q <= 1'b0;
        end else begin
            busy_q <= new_evt | (busy_q & ~ch.all_ready);
            ovr_q <= new_evt & (busy_q | ~ch.all_ready);
        end
    end

    // Clock request while a level change waits for a tick
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            req_q <= 1'b0;
        end else if (ch.clr) begin
            req_q <= 1'b0;
        end else begin
            req_q <= clocked & ((lvl != prev_q) | sw_pend_q | ch.sw);
        end
    end

    assign ch.evt = evt_q;
    assign ch.busy = busy_q;
    assign ch.ovr = ovr_q;
    assign ch.evd = evd_q;
    assign ch.clk_req = req_q;

endmodule : evr_channel

// file: evr_periph_model.sv
// Generators and users around the router: registered levels, ready levels.
// Assumes the testbench sets levels; counts cycles with user 0 active.
`timescale 1ns/100ps
module evr_periph_model
    import evr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic stall,
    input wire logic [NUM_GEN-1:0] gen_d,
    output logic [NUM_GEN-1:0] gen_evt,
    input wire logic [NUM_USR-1:0] user_evt,
    output logic [NUM_USR-1:0] user_ready,
    output int hits
);
    initial gen_evt = '0;
    initial hits = 0;
    // Generators launch on the router clock, so sync path sees every edge
    always @(posedge ref_clk) gen_evt <= gen_d;
    // Users stall together when asked
    assign user_ready = stall ? '0 : '1;
    // Count active cycles of user 0
    always @(posedge ref_clk) hits <= hits + int'(user_evt[0]);
endmodule : evr_periph_model

// file: evr_pkg.sv
// Shared constants for the event channel router: sizes, encodings, register map.
// Assumes every design file imports it whole; no state lives here.
package evr_pkg;

    // Sizes of the routing fabric
    localparam int NUM_CH = 12;
    localparam int NUM_GEN = 82;
    localparam int NUM_USR = 42;
    localparam int GEN_W = 7;
    localparam int USEL_W = 4;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int DIV_W = 8;
    localparam logic [GEN_W-1:0] GEN_MAX = 7'h52;

    // Channel path encodings
    localparam logic [1:0] PATH_SYNC = 2'h0;
    localparam logic [1:0] PATH_RESYNC = 2'h1;
    localparam logic [1:0] PATH_ASYNC = 2'h2;

    // Edge detector encodings
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_DEBUG_HALT_CONTROL = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_CLKDIV = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_CHANNEL_STATUS_REG = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_INTERRUPT_FLAG_REG = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_SOFTWARE_TRIGGER_REG = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_CH_BASE = 12'h020;
    localparam logic [ADDR_W-1:0] OFS_USR_BASE = 12'h080;

    // Field positions
    localparam int SRST_BIT = 0;
    localparam int DBG_RUN_BIT = 0;
    localparam int GEN_LSB = 0;
    localparam int PATH_LSB = 8;
    localparam int EDGE_LSB = 10;
    localparam int HI_LSB = 16;

    // Reset values
    localparam logic [GEN_W-1:0] GEN_RST = 7'h00;
    localparam logic [1:0] PATH_RST = PATH_SYNC;
    localparam logic [1:0] EDGE_RST = EDGE_NONE;
    localparam logic [USEL_W-1:0] USEL_RST = 4'h0;
    localparam logic [DIV_W-1:0] DIV_RST = 8'h00;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : evr_pkg

// file: evr_router.sv
// Event channel router top: AXI4-Lite registers, channel engines, user muxes.
// Assumes generators, users and sleep/debug controls all run on ref_clk.
// Behaviour
// - Twelve channels, each with own generator and path
// - Any of 82 generators feeds any channel
// - One generator per channel at a time
// - Each of 42 users selects one channel
// - Generator select resets to zero, disconnected
// - Block is always enabled, no enable bit
// - Soft reset clears registers and pending events
// - Path select picks async, sync or resync
// - Async path passes level with no clock
// - Async channel: no flags, status reads zero
// - Sync channel keeps busy and flags updated
// - Edge detector: rise, fall or both
// - Software command issues channel event
// - Sleeping channel requests its clock on event
// - Block can wake processor from sleep
// - Runs in debug halt unless told halt
// - Guard protects all but status and flags
// - Debug halt or external debugger bypass guard
// - Sync path delivers within one channel tick
// - Resync path delivers within three ticks
// - Overrun only on clocked paths, busy or unready
// - Software trigger bit acts like generator event
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
module evr_router
    import evr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_GEN-1:0] gen_evt,
    output logic [NUM_USR-1:0] user_evt,
    input wire logic [NUM_USR-1:0] user_ready,
    input wire logic sleep_mode,
    input wire logic cpu_dbg_halt,
    input wire logic ext_debug_access,
    input wire logic guard_lock,
    output logic [NUM_CH-1:0] chan_clk_req,
    output logic wake_req
);

    // Configuration state
    logic [GEN_W-1:0] ch_gen_q [NUM_CH];    // Generator select per channel
    logic [1:0] ch_path_q [NUM_CH];         // Path select per channel
    logic [1:0] ch_edge_q [NUM_CH];         // Edge select per channel
    logic [USEL_W-1:0] usr_sel_q [NUM_USR]; // Channel chosen by each user, 0 = none
    logic [DIV_W-1:0] clkdiv_q;             // Channel tick divider
    logic [DIV_W-1:0] div_cnt_q;            // Divider counter
    logic dbg_halt_en_q;                    // Halt channels while the CPU is halted
    logic [NUM_CH-1:0] ovr_flag_q;          // Sticky overrun flags
    logic [NUM_CH-1:0] evd_flag_q;          // Sticky event detected flags
    logic srst_q;                           // Soft reset pulse
    logic wake_q;                           // Wake request

    // AXI slave state
    logic aw_full_q;
    logic w_full_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [DATA_W-1:0] rdata_q;

    // Channel results gathered into vectors
    logic [NUM_CH-1:0] ch_evt;
    logic [NUM_CH-1:0] ch_busy;
    logic [NUM_CH-1:0] ch_ovr;
    logic [NUM_CH-1:0] ch_evd;
    logic [NUM_CH-1:0] ch_req;
    logic [NUM_CH-1:0] ch_src;
    logic [NUM_CH-1:0] ch_async;
    logic [NUM_CH-1:0] ch_tick;
    logic [NUM_CH-1:0] all_rdy;
    logic [NUM_CH-1:0] sw_go;
    logic [NUM_CH-1:0] usr_map [NUM_USR]; // Which channel each user listens to

    // Index 0 of the extended vector is the "no generator" source
    wire [NUM_GEN:0] gen_ext = {gen_evt, 1'b0};

    // Divider makes the channel tick; debug halt may freeze it
    wire base_tick = (div_cnt_q == clkdiv_q);
    wire halted = cpu_dbg_halt & dbg_halt_en_q;
    // Registered soft reset joins the power-on reset; both restore one set of values
    wire cfg_rst_n = arst_n & ~srst_q;

    // Write side decode
    wire wr_go = aw_full_q & w_full_q & ~bvalid_q;
    wire [ADDR_W-1:0] ch_off_w = awaddr_q - OFS_CH_BASE;
    wire [ADDR_W-1:0] us_off_w = awaddr_q - OFS_USR_BASE;
    wire wr_ch_hit = (awaddr_q >= OFS_CH_BASE) && (ch_off_w[ADDR_W-1:2] < NUM_CH);
    wire wr_us_hit = (awaddr_q >= OFS_USR_BASE) && (us_off_w[ADDR_W-1:2] < NUM_USR);
    wire wr_flag = (awaddr_q == OFS_INTERRUPT_FLAG_REG);
    wire wr_stat = (awaddr_q == OFS_CHANNEL_STATUS_REG);
    wire wr_known = wr_ch_hit | wr_us_hit | wr_flag | wr_stat | (awaddr_q == OFS_CTRL) |
                    (awaddr_q == OFS_DEBUG_HALT_CONTROL) | (awaddr_q == OFS_CLKDIV) |
                    (awaddr_q == OFS_SOFTWARE_TRIGGER_REG);
    // Guard applies except in debug halt, for the debugger, or on the exempt registers
    wire wr_open = ~guard_lock | cpu_dbg_halt | ext_debug_access | wr_flag | wr_stat;
    wire wr_ok = wr_go & wr_known & wr_open;
    wire [DATA_W-1:0] bmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire [DATA_W-1:0] wd_m = wdata_q & bmask;
    wire [USEL_W-1:0] wr_ch_idx = USEL_W'(ch_off_w[ADDR_W-1:2]);
    wire [5:0] wr_us_idx = 6'(us_off_w[ADDR_W-1:2]);
    wire do_srst = wr_ok & (awaddr_q == OFS_CTRL) & wd_m[SRST_BIT];
    wire [NUM_CH-1:0] flag_clr = (wr_ok & wr_flag) ? wd_m[NUM_CH-1:0] : '0;
    wire [NUM_CH-1:0] evd_clr = (wr_ok & wr_flag) ? wd_m[HI_LSB +: NUM_CH] : '0;
    assign sw_go = (wr_ok & (awaddr_q == OFS_SOFTWARE_TRIGGER_REG)) ? wd_m[NUM_CH-1:0] : '0;

    // Read side decode
    wire ar_go = s_axi_arvalid & arready_q;
    wire [ADDR_W-1:0] ch_off_r = s_axi_araddr - OFS_CH_BASE;
    wire [ADDR_W-1:0] us_off_r = s_axi_araddr - OFS_USR_BASE;
    wire rd_ch_hit = (s_axi_araddr >= OFS_CH_BASE) && (ch_off_r[ADDR_W-1:2] < NUM_CH);
    wire rd_us_hit = (s_axi_araddr >= OFS_USR_BASE) && (us_off_r[ADDR_W-1:2] < NUM_USR);
    wire [USEL_W-1:0] rd_ch_idx = USEL_W'(ch_off_r[ADDR_W-1:2]);
    wire [5:0] rd_us_idx = 6'(us_off_r[ADDR_W-1:2]);
    wire [NUM_CH-1:0] usr_rdy_vis = all_rdy & ~ch_async;
    wire [DATA_W-1:0] stat_word = DATA_W'({usr_rdy_vis, 4'h0, ch_busy});
    wire [DATA_W-1:0] flag_word = DATA_W'({evd_flag_q & ~ch_async, 4'h0, ovr_flag_q & ~ch_async});
    wire [DATA_W-1:0] ch_word = DATA_W'({ch_edge_q[rd_ch_idx], ch_path_q[rd_ch_idx], 1'b0,
                                         ch_gen_q[rd_ch_idx]});
    wire [DATA_W-1:0] us_word = DATA_W'(usr_sel_q[rd_us_idx]);
    wire rd_known = rd_ch_hit | rd_us_hit | (s_axi_araddr == OFS_CTRL) |
                    (s_axi_araddr == OFS_DEBUG_HALT_CONTROL) | (s_axi_araddr == OFS_CLKDIV) |
                    (s_axi_araddr == OFS_CHANNEL_STATUS_REG) | (s_axi_araddr == OFS_INTERRUPT_FLAG_REG) |
                    (s_axi_araddr == OFS_SOFTWARE_TRIGGER_REG);
    // Control and trigger registers read as zero; they act only on write
    wire [DATA_W-1:0] rd_mux = rd_ch_hit ? ch_word :
                               rd_us_hit ? us_word :
                               (s_axi_araddr == OFS_DEBUG_HALT_CONTROL) ? DATA_W'(dbg_halt_en_q) :
                               (s_axi_araddr == OFS_CLKDIV) ? DATA_W'(clkdiv_q) :
                               (s_axi_araddr == OFS_CHANNEL_STATUS_REG) ? stat_word :
                               (s_axi_araddr == OFS_INTERRUPT_FLAG_REG) ? flag_word : '0;

    // Channel engines, one per channel
    generate
        for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
            evr_chan_if cif();
            // Out-of-range select behaves like no generator
            wire [GEN_W-1:0] gsel = (ch_gen_q[c] <= GEN_MAX) ? ch_gen_q[c] : GEN_RST;
            assign cif.src = gen_ext[gsel];
            assign cif.tick = ch_tick[c];
            assign cif.clr = srst_q;
            assign cif.path = ch_path_q[c];
            assign cif.edge_sel = ch_edge_q[c];
            assign cif.sw = sw_go[c];
            assign cif.all_ready = all_rdy[c];
            assign ch_evt[c] = cif.evt;
            assign ch_busy[c] = cif.busy;
            assign ch_ovr[c] = cif.ovr;
            assign ch_evd[c] = cif.evd;
            assign ch_req[c] = cif.clk_req;
            assign ch_src[c] = cif.src;
            assign ch_async[c] = (ch_path_q[c] == PATH_ASYNC);
            // Sleep stops the tick unless the channel asked for its clock
            assign ch_tick[c] = base_tick & ~halted & (~sleep_mode | ch_req[c]);
            evr_channel u_chan (
                .ref_clk(ref_clk),
                .arst_n(arst_n),
                .ch(cif.chan)
            );
        end
    endgenerate

    // User multiplexers; async channels bypass every flop to avoid clock latency
    generate
        for (genvar m = 0; m < NUM_USR; m++) begin : g_usr
            for (genvar c = 0; c < NUM_CH; c++) begin : g_map
                assign usr_map[m][c] = (usr_sel_q[m] == USEL_W'(c + 1));
            end
            assign user_evt[m] = |(usr_map[m] & ((ch_async & ch_src) |
                                                 (~ch_async & ch_evt)));
        end
    endgenerate

    // A channel is ready when no user attached to it is stalling
    always_comb begin
        all_rdy = '1;
        for (int m = 0; m < NUM_USR; m++) begin
            all_rdy = all_rdy & ~(usr_map[m] & {NUM_CH{~user_ready[m]}});
        end
    end

    // Tick divider
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt_q <= DIV_RST;
        end else if (srst_q || base_tick) begin
            div_cnt_q <= DIV_RST;
        end else begin
            div_cnt_q <= div_cnt_q + 8'h01;
        end
    end

    // Configuration writes; soft reset restores every reset value
    always_ff @(posedge ref_clk or negedge cfg_rst_n) begin
        if (!cfg_rst_n) begin
            for (int c = 0; c < NUM_CH; c++) begin
                ch_gen_q[c] <= GEN_RST;
                ch_path_q[c] <= PATH_RST;
                ch_edge_q[c] <= EDGE_RST;
            end
            for (int m = 0; m < NUM_USR; m++) begin
                usr_sel_q[m] <= USEL_RST;
            end
            clkdiv_q <= DIV_RST;
            dbg_halt_en_q <= 1'b0;
        end else if (wr_ok) begin
            if (wr_ch_hit && wstrb_q[0]) begin
                ch_gen_q[wr_ch_idx] <= wdata_q[GEN_LSB +: GEN_W];
            end
            if (wr_ch_hit && wstrb_q[1]) begin
                ch_path_q[wr_ch_idx] <= wdata_q[PATH_LSB +: 2];
                ch_edge_q[wr_ch_idx] <= wdata_q[EDGE_LSB +: 2];
            end
            if (wr_us_hit && wstrb_q[0]) begin
                usr_sel_q[wr_us_idx] <= wdata_q[USEL_W-1:0];
            end
            if (awaddr_q == OFS_CLKDIV && wstrb_q[0]) begin
                clkdiv_q <= wdata_q[DIV_W-1:0];
            end
            if (awaddr_q == OFS_DEBUG_HALT_CONTROL && wstrb_q[0]) begin
                dbg_halt_en_q <= wdata_q[DBG_RUN_BIT];
            end
        end
    end

    // Sticky flags: a new event wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ovr_flag_q <= '0;
            evd_flag_q <= '0;
            srst_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            srst_q <= do_srst;
            ovr_flag_q <= srst_q ? '0 : ((ovr_flag_q & ~flag_clr) | ch_ovr);
            evd_flag_q <= srst_q ? '0 : ((evd_flag_q & ~evd_clr) | ch_evd);
            wake_q <= sleep_mode & ~srst_q & (|ch_ovr | |ch_evd);
        end
    end

    // AXI write channel: address and data taken in either order
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_full_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_full_q <= 1'b0;
            end
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= !wr_known ? RESP_DECERR : (!wr_open ? RESP_SLVERR : RESP_OKAY);
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // AXI read channel: one read at a time, answered the cycle after the address
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
        end else begin
            arready_q <= ~rvalid_q & ~ar_go;
            if (ar_go) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= rd_known ? RESP_OKAY : RESP_DECERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_awready = ~aw_full_q;
    assign s_axi_wready = ~w_full_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign chan_clk_req = ch_req;
    assign wake_req = wake_q;

endmodule : evr_router

// file: evr_router_chk.sv
// Bus handshake and wake checks on the router top ports.
// Assumes a single ref_clk domain; bound onto every router instance.
`timescale 1ns/100ps
module evr_router_chk
    import evr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleep_mode,
    input wire logic wake_req
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // Address and data taken on one edge
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Read address taken
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_AW_TAKEN: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("awready stayed high after address taken");
    AST_W_TAKEN: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
        else $error("wready stayed high after data taken");
    AST_B_AFTER: assert property (!s_axi_bvalid ##0 s_wr_both |=> ##1 s_axi_bvalid)
        else $error("write response late");
    AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid held after response taken");
    AST_R_AFTER: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data late or arready early");
    AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready high while read data pending");
    AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid held after data taken");
    // Wake only follows a cycle with sleep_mode high
    AST_WAKE: assert property (wake_req |-> $past(sleep_mode))
        else $error("wake request outside sleep");
endmodule : evr_router_chk

bind evr_router evr_router_chk u_chk (.*);

// file: tb_event_channel_router.sv
// Register-driven tests of the router through AXI4-Lite and a peripheral model.
// Assumes the checker binds itself; the design runs on one 200 MHz clock.
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module tb_event_channel_router;
    import evr_pkg::*;
    logic ref_clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, stall, sleep_mode, cpu_dbg_halt, ext_debug_access, guard_lock;
    logic wake_req;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [NUM_GEN-1:0] gen_d, gen_evt;
    logic [NUM_USR-1:0] user_evt, user_ready;
    logic [NUM_CH-1:0] chan_clk_req;
    int hits, h;
    int err_total = 0;
    int check_count = 0;
    evr_router DUT (.*);
    evr_periph_model u_periph (.*);
    initial begin
        ref_clk = 0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // Write one word, hold bready until the response, then compare it
    task automatic wx(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
        `CHK(s_axi_bresp, e)
    endtask : wx
    // Read one word and compare the masked data and the response code
    task automatic rx(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
            input logic [1:0] er);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 0;
        `CHK(s_axi_rdata & m, e)
        `CHK(s_axi_rresp, er)
    endtask : rx
    // Set generator 1 level, then allow the path latency to pass
    task automatic lvl(input logic v);
        @(posedge ref_clk);
        gen_d[0] <= v;
        repeat (6) @(posedge ref_clk);
    endtask : lvl
    task automatic finish_test;
        if (err_total == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    // Cut a hang short; the sequence needs under two hundred cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        finish_test();
    end
    initial begin
        {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, stall, sleep_mode, cpu_dbg_halt, ext_debug_access, guard_lock} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, gen_d} = '0;
        s_axi_wstrb = 4'hf;
        repeat (20) @(posedge ref_clk);
        arst_n <= 1;
        rx(OFS_CH_BASE, 32'h0, 32'hffffffff, RESP_OKAY);
        rx(OFS_CTRL, 32'h0, 32'hffffffff, RESP_OKAY);
        rx(12'hffc, 32'h0, 32'h0, RESP_DECERR);
        wx(OFS_USR_BASE, 32'h1, RESP_OKAY);
        wx(OFS_CH_BASE, 32'h401, RESP_OKAY);
        lvl(1);
        lvl(0);
        `CHK(hits, 1)
        rx(OFS_INTERRUPT_FLAG_REG, 32'h10000, 32'h10000, RESP_OKAY);
        wx(OFS_CH_BASE, 32'hc01, RESP_OKAY);
        lvl(1);
        lvl(0);
        `CHK(hits, 3)
        wx(OFS_SOFTWARE_TRIGGER_REG, 32'h1, RESP_OKAY);
        repeat (4) @(posedge ref_clk);
        `CHK(hits, 4)
        stall <= 1;
        wx(OFS_SOFTWARE_TRIGGER_REG, 32'h1, RESP_OKAY);
        wx(OFS_SOFTWARE_TRIGGER_REG, 32'h1, RESP_OKAY);
        rx(OFS_CHANNEL_STATUS_REG, 32'h1, 32'h1, RESP_OKAY);
        rx(OFS_INTERRUPT_FLAG_REG, 32'h1, 32'h1, RESP_OKAY);
        stall <= 0;
        wx(OFS_CH_BASE, 32'h201, RESP_OKAY);
        lvl(1);
        `CHK(user_evt[0], gen_evt[0])
        rx(OFS_CHANNEL_STATUS_REG, 32'h0, 32'h10001, RESP_OKAY);
        rx(OFS_INTERRUPT_FLAG_REG, 32'h0, 32'h10001, RESP_OKAY);
        guard_lock <= 1;
        wx(OFS_CH_BASE, 32'h401, RESP_SLVERR);
        wx(OFS_INTERRUPT_FLAG_REG, 32'hffffffff, RESP_OKAY);
        cpu_dbg_halt <= 1;
        wx(OFS_USR_BASE, 32'h1, RESP_OKAY);
        cpu_dbg_halt <= 0;
        ext_debug_access <= 1;
        wx(OFS_CH_BASE, 32'h401, RESP_OKAY);
        {ext_debug_access, guard_lock} <= 2'b00;
        lvl(0);
        h = hits;
        sleep_mode <= 1;
        @(posedge ref_clk);
        gen_d[0] <= 1;
        repeat (3) @(posedge ref_clk);
        `CHK(chan_clk_req[0], 1'b1)
        repeat (2) @(posedge ref_clk);
        `CHK(wake_req, 1'b1)
        `CHK(hits, h + 1)
        sleep_mode <= 0;
        wx(OFS_CTRL, 32'h1, RESP_OKAY);
        rx(OFS_CH_BASE, 32'h0, 32'hffffffff, RESP_OKAY);
        rx(OFS_USR_BASE, 32'h0, 32'hffffffff, RESP_OKAY);
        finish_test();
    end
endmodule : tb_event_channel_router
